// >>> shared/supply_cfg_map.svh
// register map, field positions and timing constants of the supply config block
`ifndef SUPPLY_CFG_MAP_SVH
`define SUPPLY_CFG_MAP_SVH

// ****************************************************************
// register indices (byte address is index times four, cut to 16 bits, word aligned)
// ****************************************************************
`define IDX_SOFT_RESET      16'hFE88
`define IDX_UPDATE_RATE     16'hFE89
`define IDX_OTW_SETTINGS    16'hFE8A
`define IDX_IRQ_STATUS      16'hFE8B
`define IDX_IRQ_MASK        16'hFE8C
`define IDX_CHAN_STATUS     16'hFE8D
`define ADDR_SHIFT          2

// ****************************************************************
// field positions
// ****************************************************************
`define SR_TRIG_FIRST       0
`define SR_TRIG_SECOND      1
`define SR_DELAY_LO         2
`define SR_DELAY_HI         3
`define OW_THR1_LO          0
`define OW_THR1_HI          1
`define OW_ROUTE1           2
`define OW_NODEB1           3
`define OW_THR2_LO          4
`define OW_THR2_HI          5
`define OW_ROUTE2           6
`define OW_NODEB2           7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_SOFT_RESET      8'h00
`define RST_UPDATE_RATE     8'h00
`define RST_OTW_SETTINGS    8'h00
`define RST_IRQ             4'h0

// ****************************************************************
// times in their own units and clock rate
// ****************************************************************
`define CLK_HZ              100000000
`define DELAY_500_MS        500
`define DELAY_1_SEC         1
`define DELAY_2_SEC         2
`define RATE_0_US           10500
`define RATE_1_US           52400
`define RATE_2_US           104900
`define RATE_3_US           209700
`define DEBOUNCE_MS         100
`define MS_CYC              (`CLK_HZ / 1000)
`define US_CYC              (`CLK_HZ / 1000000)
`define SYNC_DEPTH          3

`endif

// >>> shared/supply_cfg_pkg.sv
// types of the supply config block
package supply_cfg_pkg;
    typedef enum logic [1:0] {
        CH_ON   = 2'b00,
        CH_OFF  = 2'b01,
        CH_WAIT = 2'b11
    } chan_state_e;
    typedef logic [7:0] cfg_byte_t;
endpackage

// >>> logic/pin_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    wire  agree = (s2_ff == s3_ff);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            s1_ff  <= 1'b0;
            s2_ff  <= 1'b0;
            s3_ff  <= 1'b0;
            lvl_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (agree) begin
                lvl_ff <= s3_ff;
            end
        end
    end
    assign level_out = lvl_ff;
endmodule

// >>> logic/warn_debounce.sv
// over-temperature warning comparator with optional debounce
`timescale 1ns/1ps
module warn_debounce #(
    parameter int          SENSE_W  = 12,
    parameter int unsigned DEB_CYC  = 10000000
) (
    input  wire logic               core_clk_in,
    input  wire logic               rst_in,
    input  wire logic [SENSE_W-1:0] sense_in,
    input  wire logic [SENSE_W-1:0] trip_in,
    input  wire logic [1:0]         offset_code_in,
    input  wire logic               no_debounce_in,
    output logic                    warn_out
);
    localparam int CW = $clog2(DEB_CYC + 1);
    logic [CW-1:0] cnt_ff;
    logic          warn_ff;
    wire  [SENSE_W:0] steps = {{(SENSE_W-1){1'b0}}, offset_code_in} + 1'b1;
    wire  [SENSE_W:0] thresh = {1'b0, trip_in} + steps;
    wire  over = ({1'b0, sense_in} >= thresh);
    wire  full = (cnt_ff == CW'(DEB_CYC - 1));

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_ff  <= '0;
            warn_ff <= 1'b0;
        end else if (!over) begin
            cnt_ff  <= '0;
            warn_ff <= 1'b0;
        end else if (no_debounce_in || full) begin
            warn_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    assign warn_out = warn_ff;
endmodule

// >>> logic/supply_reset_and_overtemp_warning_cfg.sv
// supply soft reset, converter update rate and over-temperature warning cfg
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "supply_cfg_map.svh"

// Overview of operation
// - two-bit restart delay: none, 500 ms, one second or two seconds
// - second trigger bit turns second supply off, waits delay, restarts
// - first trigger bit turns first supply off, waits shared delay, restarts
// - two-bit update rate field: 10.5, 52.4, 104.9 or 209.7 ms
// - bit 7 chooses 100 ms or no debounce for second warning
// - bit 6 lets second warning raise second power-good fault
// - bits 5:4 put second threshold one to four steps above trip
// - bit 3 chooses 100 ms or no debounce for first warning
// - bit 2 lets first warning raise first power-good fault
// - bits 1:0 put first threshold one to four steps above trip
// - power-good fault drives its pin low; fault has several sources
module supply_reset_and_overtemp_warning_cfg
    import supply_cfg_pkg::*;
#(
    parameter int          SENSE_W   = 12,
    parameter int unsigned DEB_CYC   = `DEBOUNCE_MS * `MS_CYC,
    parameter int unsigned D500_CYC  = `DELAY_500_MS * `MS_CYC,
    parameter int unsigned D1S_CYC   = `DELAY_1_SEC * `CLK_HZ,
    parameter int unsigned D2S_CYC   = `DELAY_2_SEC * `CLK_HZ,
    parameter int unsigned RATE0_CYC = `RATE_0_US * `US_CYC,
    parameter int unsigned RATE1_CYC = `RATE_1_US * `US_CYC,
    parameter int unsigned RATE2_CYC = `RATE_2_US * `US_CYC,
    parameter int unsigned RATE3_CYC = `RATE_3_US * `US_CYC
) (
    input  wire logic               core_clk_in,
    input  wire logic               rst_in,
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [15:0]        wb_adr_in,
    input  wire logic [31:0]        wb_dat_in,
    input  wire logic [3:0]         wb_sel_in,
    output logic [31:0]             wb_dat_out,
    output logic                    wb_ack_out,
    output logic                    irq_out,
    input  wire logic [SENSE_W-1:0] temp_sense_one_in,
    input  wire logic [SENSE_W-1:0] temp_sense_two_in,
    input  wire logic [SENSE_W-1:0] overtemp_trip_one_in,
    input  wire logic [SENSE_W-1:0] overtemp_trip_two_in,
    input  wire logic               other_fault_first_in,
    input  wire logic               other_fault_second_in,
    output logic                    supply_on_first_out,
    output logic                    supply_on_second_out,
    output logic                    power_good_first_n_out,
    output logic                    power_good_second_n_out,
    output logic                    adc_update_out,
    output logic                    overtemp_warning_one_out,
    output logic                    overtemp_warning_two_out
);
    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    cfg_byte_t soft_reset_ff;
    cfg_byte_t update_rate_ff;
    cfg_byte_t otw_set_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic [31:0] rdata_ff;
    logic        ack_ff;

    wire req     = wb_cyc_in && wb_stb_in && !ack_ff;
    wire wr      = req && wb_we_in && wb_sel_in[0];
    wire hit_sr  = (wb_adr_in == (`IDX_SOFT_RESET   << `ADDR_SHIFT));
    wire hit_ur  = (wb_adr_in == (`IDX_UPDATE_RATE  << `ADDR_SHIFT));
    wire hit_ow  = (wb_adr_in == (`IDX_OTW_SETTINGS << `ADDR_SHIFT));
    wire hit_is  = (wb_adr_in == (`IDX_IRQ_STATUS   << `ADDR_SHIFT));
    wire hit_im  = (wb_adr_in == (`IDX_IRQ_MASK     << `ADDR_SHIFT));
    wire hit_cs  = (wb_adr_in == (`IDX_CHAN_STATUS  << `ADDR_SHIFT));
    wire [7:0] wbyte = wb_dat_in[7:0];

    // trigger bits are not stored; a write acts only in its own cycle and only if the channel is on
    wire trig_first  = wr && hit_sr && wbyte[`SR_TRIG_FIRST];
    wire trig_second = wr && hit_sr && wbyte[`SR_TRIG_SECOND];
    wire [1:0] delay_code = soft_reset_ff[`SR_DELAY_HI:`SR_DELAY_LO];

    chan_state_e st_first_ff;
    chan_state_e st_second_ff;
    logic        warn1;
    logic        warn2;
    logic        fault1;
    logic        fault2;
    logic        upd_pulse;

    wire [7:0] chan_stat = {4'h0, fault2, fault1,
                            (st_second_ff == CH_ON),
                            (st_first_ff == CH_ON)};
    wire [31:0] rmux =
        hit_sr ? {24'h0, soft_reset_ff} :
        hit_ur ? {24'h0, update_rate_ff} :
        hit_ow ? {24'h0, otw_set_ff} :
        hit_is ? {28'h0, irq_stat_ff} :
        hit_im ? {28'h0, irq_mask_ff} :
        hit_cs ? {24'h0, chan_stat} : 32'h0;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff   <= req;
            rdata_ff <= req ? rmux : 32'h0;
        end
    end
    assign wb_ack_out = ack_ff;
    assign wb_dat_out = rdata_ff;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    wire [7:0] nxt_soft_reset = {4'h0, wbyte[`SR_DELAY_HI:`SR_DELAY_LO],
                                 2'b00};
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            soft_reset_ff  <= `RST_SOFT_RESET;
            update_rate_ff <= `RST_UPDATE_RATE;
            otw_set_ff     <= `RST_OTW_SETTINGS;
            irq_mask_ff    <= `RST_IRQ;
        end else if (wr) begin
            if (hit_sr) soft_reset_ff <= nxt_soft_reset;
            if (hit_ur) update_rate_ff <= {6'h0, wbyte[1:0]};
            if (hit_ow) otw_set_ff <= wbyte;
            if (hit_im) irq_mask_ff <= wbyte[3:0];
        end
    end

    // ****************************************************************
    // restart delay selection
    // ****************************************************************
    localparam int DW = $clog2(D2S_CYC + 1);
    wire [DW-1:0] delay_cyc =
        (delay_code == 2'b00) ? DW'(0) :
        (delay_code == 2'b01) ? DW'(D500_CYC) :
        (delay_code == 2'b10) ? DW'(D1S_CYC) : DW'(D2S_CYC);

    // ****************************************************************
    // channel soft reset sequencers
    // ****************************************************************
    logic [DW-1:0] cnt_first_ff;
    logic [DW-1:0] cnt_second_ff;

    // one pass through off keeps the supply down for at least one cycle
    // first channel off, wait, restart
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_first_ff  <= CH_ON;
            cnt_first_ff <= '0;
        end else begin
            case (st_first_ff)
                CH_ON: begin
                    if (trig_first) st_first_ff <= CH_OFF;
                end
                CH_OFF: begin
                    cnt_first_ff <= delay_cyc;
                    st_first_ff  <= CH_WAIT;
                end
                CH_WAIT: begin
                    if (cnt_first_ff <= DW'(1)) st_first_ff <= CH_ON;
                    else cnt_first_ff <= cnt_first_ff - 1'b1;
                end
                default: st_first_ff <= CH_ON;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_second_ff  <= CH_ON;
            cnt_second_ff <= '0;
        end else begin
            case (st_second_ff)
                CH_ON: begin
                    if (trig_second) st_second_ff <= CH_OFF;
                end
                CH_OFF: begin
                    cnt_second_ff <= delay_cyc;
                    st_second_ff  <= CH_WAIT;
                end
                CH_WAIT: begin
                    if (cnt_second_ff <= DW'(1)) st_second_ff <= CH_ON;
                    else cnt_second_ff <= cnt_second_ff - 1'b1;
                end
                default: st_second_ff <= CH_ON;
            endcase
        end
    end
    assign supply_on_first_out  = (st_first_ff == CH_ON);
    assign supply_on_second_out = (st_second_ff == CH_ON);

    // ****************************************************************
    // converter update tick
    // ****************************************************************
    localparam int RW = $clog2(RATE3_CYC + 1);
    logic [RW-1:0] rate_cnt_ff;
    logic          upd_ff;
    wire [RW-1:0] rate_cyc =
        (update_rate_ff[1:0] == 2'b00) ? RW'(RATE0_CYC) :
        (update_rate_ff[1:0] == 2'b01) ? RW'(RATE1_CYC) :
        (update_rate_ff[1:0] == 2'b10) ? RW'(RATE2_CYC) : RW'(RATE3_CYC);
    wire rate_done = (rate_cnt_ff >= rate_cyc - 1'b1);
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rate_cnt_ff <= '0;
            upd_ff      <= 1'b0;
        end else begin
            upd_ff      <= rate_done;
            rate_cnt_ff <= rate_done ? '0 : rate_cnt_ff + 1'b1;
        end
    end
    assign upd_pulse      = upd_ff;
    assign adc_update_out = upd_pulse;

    // ****************************************************************
    // over-temperature warnings
    // ****************************************************************
    // first threshold offset, first debounce, persistence
    warn_debounce #(.SENSE_W(SENSE_W), .DEB_CYC(DEB_CYC)) u_warn_one (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .sense_in       (temp_sense_one_in),
        .trip_in        (overtemp_trip_one_in),
        .offset_code_in (otw_set_ff[`OW_THR1_HI:`OW_THR1_LO]),
        .no_debounce_in (otw_set_ff[`OW_NODEB1]),
        .warn_out       (warn1)
    );
    // second threshold offset, second debounce, persistence
    warn_debounce #(.SENSE_W(SENSE_W), .DEB_CYC(DEB_CYC)) u_warn_two (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .sense_in       (temp_sense_two_in),
        .trip_in        (overtemp_trip_two_in),
        .offset_code_in (otw_set_ff[`OW_THR2_HI:`OW_THR2_LO]),
        .no_debounce_in (otw_set_ff[`OW_NODEB2]),
        .warn_out       (warn2)
    );
    assign overtemp_warning_one_out = warn1;
    assign overtemp_warning_two_out = warn2;

    // ****************************************************************
    // power-good faults
    // ****************************************************************
    logic other1;
    logic other2;
    pin_sync u_sync1 (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pin_in      (other_fault_first_in),
        .level_out   (other1)
    );
    pin_sync u_sync2 (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pin_in      (other_fault_second_in),
        .level_out   (other2)
    );
    assign fault1 = other1 || !supply_on_first_out ||
                    (warn1 && otw_set_ff[`OW_ROUTE1]);
    assign fault2 = other2 || !supply_on_second_out ||
                    (warn2 && otw_set_ff[`OW_ROUTE2]);
    assign power_good_first_n_out  = !fault1;
    assign power_good_second_n_out = !fault2;

    // ****************************************************************
    // interrupts: warn1, warn2, restart done first, restart done second
    // ****************************************************************
    logic warn1_d_ff;
    logic warn2_d_ff;
    logic on1_d_ff;
    logic on2_d_ff;
    wire [3:0] ev = {supply_on_second_out && !on2_d_ff,
                     supply_on_first_out && !on1_d_ff,
                     warn2 && !warn2_d_ff,
                     warn1 && !warn1_d_ff};
    wire [3:0] clr = (wr && hit_is) ? wbyte[3:0] : 4'h0;
    // set wins over clear
    wire [3:0] nxt_irq_stat = (irq_stat_ff & ~clr) | ev;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_stat_ff <= `RST_IRQ;
            warn1_d_ff  <= 1'b0;
            warn2_d_ff  <= 1'b0;
            on1_d_ff    <= 1'b1;
            on2_d_ff    <= 1'b1;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            warn1_d_ff  <= warn1;
            warn2_d_ff  <= warn2;
            on1_d_ff    <= supply_on_first_out;
            on2_d_ff    <= supply_on_second_out;
        end
    end
    assign irq_out = |(irq_stat_ff & irq_mask_ff);
endmodule

// >>> verif/supply_cfg_sva.sv
// port assertions for the supply config block, with its bind
`timescale 1ns/1ps
`include "supply_cfg_map.svh"
module supply_cfg_sva #(
    parameter int          SENSE_W = 12,
    parameter int unsigned D2S_CYC = `DELAY_2_SEC * `CLK_HZ
) (
    input wire logic               core_clk_in,
    input wire logic               rst_in,
    input wire logic               wb_cyc_in,
    input wire logic               wb_stb_in,
    input wire logic               wb_we_in,
    input wire logic [15:0]        wb_adr_in,
    input wire logic [31:0]        wb_dat_in,
    input wire logic [3:0]         wb_sel_in,
    input wire logic [31:0]        wb_dat_out,
    input wire logic               wb_ack_out,
    input wire logic [SENSE_W-1:0] temp_sense_one_in,
    input wire logic [SENSE_W-1:0] overtemp_trip_one_in,
    input wire logic               supply_on_first_out,
    input wire logic               supply_on_second_out,
    input wire logic               power_good_first_n_out,
    input wire logic               power_good_second_n_out,
    input wire logic               adc_update_out,
    input wire logic               overtemp_warning_one_out
);
    // ********************
    // helper logic
    // ********************
    localparam logic [15:0] SR_ADR = 16'(`IDX_SOFT_RESET << `ADDR_SHIFT);
    logic [31:0] off_one_ff;
    logic [31:0] off_two_ff;

    // counters, since the off time runs far past any repetition bound
    always_ff @(posedge core_clk_in) begin
        off_one_ff <= (rst_in || supply_on_first_out) ? 32'h0
                                                      : off_one_ff + 32'h1;
        off_two_ff <= (rst_in || supply_on_second_out) ? 32'h0
                                                       : off_two_ff + 32'h1;
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence trig_write(int b);
        wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == SR_ADR
            && wb_dat_in[b];
    endsequence

    // ********************
    // assertions
    // ********************
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held past one cycle");
    ack_answer_a: assert property (
        $rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out)
        else $error("no ack one cycle after request");
    read_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data not zero outside ack");
    read_upper_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    trig_off_one_a: assert property (
        trig_write(0) ##0 $past(supply_on_first_out)
        |-> ##[0:2] !supply_on_first_out)
        else $error("first supply stayed on");
    trig_off_two_a: assert property (
        trig_write(1) ##0 $past(supply_on_second_out)
        |-> ##[0:2] !supply_on_second_out)
        else $error("second supply stayed on");
    // the off state itself adds one cycle ahead of the delay
    restart_one_a: assert property (off_one_ff <= D2S_CYC + 1)
        else $error("first supply off too long");
    restart_two_a: assert property (off_two_ff <= D2S_CYC + 1)
        else $error("second supply off too long");
    pg_off_one_a: assert property (
        !supply_on_first_out |-> !power_good_first_n_out)
        else $error("first power good high while off");
    pg_off_two_a: assert property (
        !supply_on_second_out |-> !power_good_second_n_out)
        else $error("second power good high while off");
    warn_floor_a: assert property ($rose(overtemp_warning_one_out) |->
        $past(temp_sense_one_in) > $past(overtemp_trip_one_in))
        else $error("warning rose below threshold");
    warn_clear_a: assert property (
        temp_sense_one_in <= overtemp_trip_one_in |=>
        !overtemp_warning_one_out)
        else $error("warning held without condition");
    adc_pulse_a: assert property (adc_update_out |=> !adc_update_out)
        else $error("update tick wider than one cycle");
endmodule

bind supply_reset_and_overtemp_warning_cfg supply_cfg_sva #(
    .SENSE_W (SENSE_W),
    .D2S_CYC (D2S_CYC)
) checker_inst (.*);

// >>> verif/testbench.sv
// self-checking bench for the supply config block
`timescale 1ns/1ps
`include "supply_cfg_map.svh"
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("BAD %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module testbench;
    localparam int DEB = 20;
    // code 00 still spends one wait cycle
    localparam int DLY [4] = '{1, 30, 60, 120};
    localparam int RATE [4] = '{16, 32, 48, 64};
    localparam logic [15:0] REGS [6] = '{`IDX_SOFT_RESET, `IDX_UPDATE_RATE,
        `IDX_OTW_SETTINGS, `IDX_IRQ_STATUS, `IDX_IRQ_MASK, 16'h0000};
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [15:0] wb_adr_in = 16'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [11:0] temp_sense_one_in = 12'h0, temp_sense_two_in = 12'h0;
    logic [11:0] overtemp_trip_one_in = 12'h100;
    logic [11:0] overtemp_trip_two_in = 12'h100;
    logic        other_fault_first_in = 1'b0, other_fault_second_in = 1'b0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out, irq_out, adc_update_out;
    logic        supply_on_first_out, supply_on_second_out;
    logic        power_good_first_n_out, power_good_second_n_out;
    logic        overtemp_warning_one_out, overtemp_warning_two_out;
    logic [1:0]  on_v, warn_v, pgn_v, code;
    logic [7:0]  q, sv;
    int          comparisons = 0, n_mismatch = 0, cycles = 0, n, ch;

    assign on_v = {supply_on_second_out, supply_on_first_out};
    assign warn_v = {overtemp_warning_two_out, overtemp_warning_one_out};
    assign pgn_v = {power_good_second_n_out, power_good_first_n_out};

    supply_reset_and_overtemp_warning_cfg #(
        .SENSE_W(12), .DEB_CYC(DEB), .D500_CYC(DLY[1]), .D1S_CYC(DLY[2]),
        .D2S_CYC(DLY[3]), .RATE0_CYC(RATE[0]), .RATE1_CYC(RATE[1]),
        .RATE2_CYC(RATE[2]), .RATE3_CYC(RATE[3])
    ) dut (
        .core_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
        .wb_dat_in, .wb_sel_in, .wb_dat_out, .wb_ack_out, .irq_out,
        .temp_sense_one_in, .temp_sense_two_in, .overtemp_trip_one_in,
        .overtemp_trip_two_in, .other_fault_first_in, .other_fault_second_in,
        .supply_on_first_out, .supply_on_second_out, .power_good_first_n_out,
        .power_good_second_n_out, .adc_update_out, .overtemp_warning_one_out,
        .overtemp_warning_two_out
    );

    always #5 core_clk_in = ~core_clk_in;

    // hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ********************
    // bus and helper tasks
    // ********************
    task automatic bus(input logic [15:0] idx, input logic w,
                       input logic [7:0] d);
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= 16'(idx << `ADDR_SHIFT);
        wb_dat_in <= {24'h0, d};
        wb_sel_in <= 4'h1;
        @(posedge core_clk_in);
        while (wb_ack_out !== 1'b1) @(posedge core_clk_in);
        q = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    task automatic low_len(input int c, output int k);
        k = 0;
        while (on_v[c] === 1'b1 && k < 4) begin
            @(posedge core_clk_in);
            k++;
        end
        k = 0;
        while (on_v[c] !== 1'b1 && k < 300) begin
            @(posedge core_clk_in);
            k++;
        end
    endtask

    task automatic tick_gap(output int k);
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (adc_update_out !== 1'b1 && k < 200);
    endtask

    // channel 2 means both sensors
    task automatic set_sense(input int c, input logic [11:0] v);
        if (c != 1) temp_sense_one_in <= v;
        if (c != 0) temp_sense_two_in <= v;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(REGS[i], 1'b0, 8'h00);
            `CHK("reset value", 8'h00, q)
        end
        bus(16'h0000, 1'b1, 8'hFF);
        bus(16'h0000, 1'b0, 8'h00);
        `CHK("unmapped", 8'h00, q)
        for (int c = 0; c < 4; c++) begin
            bus(`IDX_IRQ_MASK, 1'b1, c[1] ? 8'h0C : 8'h00);
            bus(`IDX_SOFT_RESET, 1'b1, {4'h0, 2'(c), c[0] ? 2'b10 : 2'b01});
            low_len(c % 2, n);
            `CHK("off cycles", 1 + DLY[c], n)
            bus(`IDX_SOFT_RESET, 1'b0, 8'h00);
            `CHK("delay field", {4'h0, 2'(c), 2'b00}, q)
            bus(`IDX_IRQ_STATUS, 1'b0, 8'h00);
            `CHK("restart event", c[0] ? 8'h08 : 8'h04, q)
            `CHK("restart irq", c[1], irq_out)
            bus(`IDX_IRQ_STATUS, 1'b1, 8'hFF);
            `CHK("irq cleared", 1'b0, irq_out)
        end
        for (int c = 0; c < 4; c++) begin
            bus(`IDX_UPDATE_RATE, 1'b1, 8'(c));
            bus(`IDX_UPDATE_RATE, 1'b0, 8'h00);
            `CHK("rate field", 8'(c), q)
            tick_gap(n);
            tick_gap(n);
            tick_gap(n);
            `CHK("tick period", RATE[c], n)
        end
        for (int c = 0; c < 8; c++) begin
            ch = c % 2;
            code = 2'(c / 2);
            sv = ch ? {1'b1, code[1], code, 4'h0}
                    : {4'h0, 1'b1, code[1], code};
            bus(`IDX_OTW_SETTINGS, 1'b1, sv);
            bus(`IDX_OTW_SETTINGS, 1'b0, 8'h00);
            `CHK("warn cfg", sv, q)
            set_sense(ch, 12'h100 + 12'(code));
            repeat (3) @(posedge core_clk_in);
            `CHK("warn below", 1'b0, warn_v[ch])
            set_sense(ch, 12'h101 + 12'(code));
            repeat (3) @(posedge core_clk_in);
            `CHK("warn above", 1'b1, warn_v[ch])
            `CHK("pg route", ~code[1], pgn_v[ch])
            set_sense(ch, 12'h000);
            repeat (2) @(posedge core_clk_in);
            `CHK("warn clear", 1'b0, warn_v[ch])
        end
        bus(`IDX_OTW_SETTINGS, 1'b1, 8'h00);
        bus(`IDX_IRQ_STATUS, 1'b1, 8'hFF);
        bus(`IDX_IRQ_MASK, 1'b1, 8'h03);
        set_sense(2, 12'h101);
        repeat (DEB / 2) @(posedge core_clk_in);
        set_sense(2, 12'h000);
        @(posedge core_clk_in);
        set_sense(2, 12'h101);
        repeat (DEB - 2) @(posedge core_clk_in);
        `CHK("debounce hold", 2'b00, warn_v)
        repeat (5) @(posedge core_clk_in);
        `CHK("debounce done", 2'b11, warn_v)
        `CHK("warn irq", 1'b1, irq_out)
        bus(`IDX_IRQ_STATUS, 1'b1, 8'hFF);
        `CHK("warn irq clear", 1'b0, irq_out)
        set_sense(2, 12'h000);
        other_fault_first_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        `CHK("fault first", 2'b10, pgn_v)
        bus(`IDX_CHAN_STATUS, 1'b0, 8'h00);
        `CHK("chan status", 8'h07, q)
        other_fault_first_in <= 1'b0;
        other_fault_second_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        `CHK("fault second", 2'b01, pgn_v)
        other_fault_second_in <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        `CHK("fault gone", 2'b11, pgn_v)
        conclude();
    end
endmodule
